// ==== design/gpio_port_pkg.sv ====
// constants, command codes and field layout for the five-pin gpio port
// assumes a packet framer outside that delivers parsed command bytes
package gpio_port_pkg;
  localparam int unsigned PIN_COUNT = 5;
  localparam int unsigned PIN_INDEX_W = 8;
  localparam logic [7:0] CMD_SET_PIN = 8'h22;
  localparam logic [7:0] CMD_READ_PIN = 8'h23;
  localparam logic [7:0] RESP_ACK_BIT = 8'h40;
  localparam logic [7:0] RESP_ERROR = 8'hc0;
  localparam logic [7:0] LEVEL_LOW = 8'h00;
  localparam logic [7:0] LEVEL_HIGH = 8'h64;
  localparam logic [7:0] CONFIG_MAX = 8'h0f;
  localparam logic [2:0] DRIVE_RESERVED = 3'h6;
  localparam logic [2:0] DRIVE_STRONG_UP_RES_DOWN = 3'h0;
  localparam logic [2:0] DRIVE_STRONG_BOTH = 3'h1;
  localparam logic [2:0] DRIVE_HIGH_IMPEDANCE = 3'h2;
  localparam logic [2:0] DRIVE_RES_UP_STRONG_DOWN = 3'h3;
  localparam logic [2:0] DRIVE_SLOW_UP_HIZ = 3'h4;
  localparam logic [2:0] DRIVE_SLOW_BOTH = 3'h5;
  localparam logic [2:0] DRIVE_HIZ_SLOW_DOWN = 3'h7;
  localparam int unsigned CFG_FUNC_BIT = 3;
  localparam int unsigned STATE_LEVEL_BIT = 0;
  localparam int unsigned STATE_FALL_BIT = 1;
  localparam int unsigned STATE_RISE_BIT = 2;
  localparam int unsigned SET_LEN_VALUE = 2;
  localparam int unsigned SET_LEN_CONFIG = 3;
  localparam int unsigned READ_LEN = 1;
  localparam int unsigned READ_RESP_LEN = 4;
  // timing
  localparam longint unsigned CLK_HZ = 125000000;
  localparam longint unsigned SAMPLE_HZ = 32;
  localparam longint unsigned PWM_HZ = 100;
  localparam int unsigned PWM_STEPS = 100;
  localparam int unsigned SAMPLE_CYCLES = int'(CLK_HZ / SAMPLE_HZ);
  localparam int unsigned PWM_STEP_CYCLES = int'(CLK_HZ / (PWM_HZ * PWM_STEPS));
  // power-up defaults: output low, alternate function, resistive pull down
  localparam logic [7:0] DEFAULT_LEVEL = 8'h00;
  localparam logic [7:0] DEFAULT_CONFIG = 8'h00;
endpackage

// ==== design/pulse_divider.sv ====
// free-running divider giving a one-cycle tick every period cycles
// assumes period is at least two
`timescale 1ns/100ps
module pulse_divider #(
  parameter int unsigned PERIOD = 10
) (
  input wire logic sys_clk,
  input wire logic rst,
  output logic tick
);
  logic [31:0] count_reg;
  logic [31:0] count_next;

  always_comb begin
    if (count_reg == 32'(PERIOD - 1)) begin
      count_next = 32'h0;
    end else begin
      count_next = count_reg + 32'h1;
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      count_reg <= 32'h0;
    end else begin
      count_reg <= count_next;
    end
  end

  assign tick = (count_reg == 32'(PERIOD - 1));
endmodule // pulse_divider

// ==== design/pin_pwm.sv ====
// one pin's pwm generator: level 0 low, 1-99 duty, 100 high
// assumes step_tick pulses 100 times per pwm period
`timescale 1ns/100ps
module pin_pwm
  import gpio_port_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic step_tick,
  input wire logic [7:0] level,
  output logic pwm_out
);
  logic [6:0] phase_reg;
  logic [6:0] phase_next;
  logic pwm_reg;
  logic pwm_next;

  always_comb begin
    phase_next = phase_reg;
    if (step_tick) begin
      phase_next = (phase_reg == 7'(PWM_STEPS - 1)) ? 7'h0 : phase_reg + 7'h1;
    end
    pwm_next = ({1'b0, phase_reg} < level);
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      phase_reg <= 7'h0;
      pwm_reg <= 1'b0;
    end else begin
      phase_reg <= phase_next;
      pwm_reg <= pwm_next;
    end
  end

  assign pwm_out = pwm_reg;
endmodule // pin_pwm

// ==== design/gpio_pwm_port_control.sv ====
// five-pin gpio port: set/read commands, 100 Hz pwm, 32 Hz sampling
// assumes a framer delivers one parsed command per cmd_valid pulse
// Behaviour
// (R1) five pins at index 0-4; index 5 and above reach no pin
// (R2) set command 0x22 takes two bytes, or three to also configure
// (R3) level 0 low, 1-99 pwm duty, 100 high, 101-254 invalid
// (R4) duty levels produce a 100 Hz pwm waveform on the pin
// (R5) config byte valid 0-15; upper bits reserved, written zero
// (R6) three-bit driver_select chooses high and low driver behaviour
// (R7) driver_select 110 reserved; set carrying it gets error response
// (R8) function bit: clear gives alternate function, set gives user gpio
// (R9) read command 0x23 carries one byte, the pin index
// (R10) read answer: index, state byte, requested level, config byte
// (R11) every pin sampled at 32 Hz regardless of configuration
// (R12) rising and falling flags latch on sample change until read
// (R13) state byte: bit0 level, bit1 falling, bit2 rising, rest zero
// (R14) reported level is the actual sampled pin level
// (R15) only low-rate samples seen, so short glitches are ignored
// (R16) reserved config bits always read back as zero
// (R17) level, function and drive captured on save as power-up default; reset loads DEFAULT_LEVEL and DEFAULT_CONFIG, not the saved copies
// (R18) success answered with type equal to command type or 0x40
// (R19) reading a pin clears both its edge flags after reporting
// (R20) bad index, level or config rejected with error, pin unchanged
`timescale 1ns/100ps
module gpio_pwm_port_control
  import gpio_port_pkg::*;
#(
  parameter int unsigned PINS = PIN_COUNT,
  parameter int unsigned SAMPLE_PERIOD = SAMPLE_CYCLES,
  parameter int unsigned PWM_STEP_PERIOD = PWM_STEP_CYCLES
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic cmd_valid,
  input wire logic [7:0] cmd_type,
  input wire logic [1:0] cmd_length,
  input wire logic [7:0] cmd_data0,
  input wire logic [7:0] cmd_data1,
  input wire logic [7:0] cmd_data2,
  input wire logic save_defaults,
  output logic resp_valid,
  output logic [7:0] resp_type,
  output logic [2:0] resp_length,
  output logic [7:0] resp_data0,
  output logic [7:0] resp_data1,
  output logic [7:0] resp_data2,
  output logic [7:0] resp_data3,
  input wire logic [PINS-1:0] pin_in,
  output logic [PINS-1:0] pin_out,
  output logic [PINS-1:0] pin_oe,
  output logic [PINS-1:0] pin_pull_up,
  output logic [PINS-1:0] pin_pull_down,
  output logic [PINS-1:0] pin_slow,
  output logic [PINS-1:0] pin_user_owned
);
  import gpio_port_pkg::*;

  logic sample_tick;
  logic step_tick;
  logic [PINS-1:0] pwm_level;
  logic [7:0] level_reg [PINS];
  logic [7:0] level_next [PINS];
  logic [7:0] config_reg [PINS];
  logic [7:0] config_next [PINS];
  logic [7:0] saved_level_reg [PINS];
  logic [7:0] saved_config_reg [PINS];
  logic [PINS-1:0] sample_reg, sample_next;
  logic [PINS-1:0] rise_reg, rise_next;
  logic [PINS-1:0] fall_reg, fall_next;
  logic resp_valid_reg, resp_valid_next;
  logic [7:0] resp_type_reg, resp_type_next;
  logic [2:0] resp_length_reg, resp_length_next;
  logic [7:0] resp_d0_reg, resp_d0_next;
  logic [7:0] resp_d1_reg, resp_d1_next;
  logic [7:0] resp_d2_reg, resp_d2_next;
  logic [7:0] resp_d3_reg, resp_d3_next;
  logic index_ok;
  logic set_cmd, read_cmd, set_ok;
  logic [2:0] pin_sel;

  pulse_divider #(.PERIOD(SAMPLE_PERIOD)) sample_div (
    .sys_clk(sys_clk),
    .rst(rst),
    .tick(sample_tick)
  );

  pulse_divider #(.PERIOD(PWM_STEP_PERIOD)) step_div (
    .sys_clk(sys_clk),
    .rst(rst),
    .tick(step_tick)
  );

  assign index_ok = (cmd_data0 < 8'(PINS)); // R1
  assign pin_sel = cmd_data0[2:0];
  assign set_cmd = cmd_valid && (cmd_type == CMD_SET_PIN);
  assign read_cmd = cmd_valid && (cmd_type == CMD_READ_PIN) && (cmd_length == 2'(READ_LEN)); // R9
  // a set needs a good index, a level of 0-100, and a legal config when present
  assign set_ok = set_cmd && index_ok // R20
    && ((cmd_length == 2'(SET_LEN_VALUE)) || (cmd_length == 2'(SET_LEN_CONFIG))) // R2
    && (cmd_data1 <= LEVEL_HIGH) // R3
    && ((cmd_length == 2'(SET_LEN_VALUE)) || ((cmd_data2 <= CONFIG_MAX) // R5
        && (cmd_data2[2:0] != DRIVE_RESERVED))); // R7

  genvar gi;
  generate
    for (gi = 0; gi < PINS; gi++) begin : g_pin
      logic [2:0] drv;
      logic want;

      pin_pwm pwm (
        .sys_clk(sys_clk),
        .rst(rst),
        .step_tick(step_tick),
        .level(level_reg[gi]),
        .pwm_out(pwm_level[gi])
      );

      always_comb begin
        level_next[gi] = level_reg[gi];
        config_next[gi] = config_reg[gi];
        if (set_ok && (pin_sel == 3'(gi))) begin
          level_next[gi] = cmd_data1;
          if (cmd_length == 2'(SET_LEN_CONFIG)) begin
            config_next[gi] = cmd_data2;
          end
        end
        sample_next[gi] = sample_tick ? pin_in[gi] : sample_reg[gi]; // R11 R14 R15
        rise_next[gi] = rise_reg[gi];
        fall_next[gi] = fall_reg[gi];
        if (read_cmd && index_ok && (pin_sel == 3'(gi))) begin
          rise_next[gi] = 1'b0; // R19
          fall_next[gi] = 1'b0;
        end
        // an edge in the read cycle survives the clear
        if (sample_tick && (pin_in[gi] != sample_reg[gi])) begin
          rise_next[gi] = rise_next[gi] | pin_in[gi]; // R12
          fall_next[gi] = fall_next[gi] | ~pin_in[gi];
        end
      end

      always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
          level_reg[gi] <= DEFAULT_LEVEL;
          config_reg[gi] <= DEFAULT_CONFIG;
          saved_level_reg[gi] <= DEFAULT_LEVEL;
          saved_config_reg[gi] <= DEFAULT_CONFIG;
          sample_reg[gi] <= 1'b0;
          rise_reg[gi] <= 1'b0;
          fall_reg[gi] <= 1'b0;
        end else begin
          level_reg[gi] <= level_next[gi];
          config_reg[gi] <= config_next[gi];
          if (save_defaults) begin
            saved_level_reg[gi] <= level_reg[gi]; // R17
            saved_config_reg[gi] <= config_reg[gi];
          end
          sample_reg[gi] <= sample_next[gi];
          rise_reg[gi] <= rise_next[gi];
          fall_reg[gi] <= fall_next[gi];
        end
      end

      // driver decode for the wanted level
      assign drv = config_reg[gi][2:0];
      assign want = pwm_level[gi]; // R4
      always_comb begin
        pin_out[gi] = want;
        pin_oe[gi] = 1'b0;
        pin_pull_up[gi] = 1'b0;
        pin_pull_down[gi] = 1'b0;
        pin_slow[gi] = 1'b0;
        case (drv) // R6
          DRIVE_STRONG_UP_RES_DOWN: begin
            pin_oe[gi] = want;
            pin_pull_down[gi] = ~want;
          end
          DRIVE_STRONG_BOTH: pin_oe[gi] = 1'b1;
          DRIVE_HIGH_IMPEDANCE: pin_oe[gi] = 1'b0;
          DRIVE_RES_UP_STRONG_DOWN: begin
            pin_oe[gi] = ~want;
            pin_pull_up[gi] = want;
          end
          DRIVE_SLOW_UP_HIZ: begin
            pin_oe[gi] = want;
            pin_slow[gi] = 1'b1;
          end
          DRIVE_SLOW_BOTH: begin
            pin_oe[gi] = 1'b1;
            pin_slow[gi] = 1'b1;
          end
          DRIVE_HIZ_SLOW_DOWN: begin
            pin_oe[gi] = ~want;
            pin_slow[gi] = 1'b1;
          end
          default: pin_oe[gi] = 1'b0;
        endcase
      end
      assign pin_user_owned[gi] = config_reg[gi][CFG_FUNC_BIT]; // R8
    end
  endgenerate

  always_comb begin
    resp_valid_next = 1'b0;
    resp_type_next = resp_type_reg;
    resp_length_next = resp_length_reg;
    resp_d0_next = resp_d0_reg;
    resp_d1_next = resp_d1_reg;
    resp_d2_next = resp_d2_reg;
    resp_d3_next = resp_d3_reg;
    if (set_cmd) begin
      resp_valid_next = 1'b1;
      resp_type_next = set_ok ? (CMD_SET_PIN | RESP_ACK_BIT) : RESP_ERROR; // R18 R7 R20
      resp_length_next = 3'h0;
    end else if (cmd_valid && (cmd_type == CMD_READ_PIN)) begin
      resp_valid_next = 1'b1;
      if (read_cmd && index_ok) begin
        resp_type_next = CMD_READ_PIN | RESP_ACK_BIT; // R18
        resp_length_next = 3'(READ_RESP_LEN); // R10
        resp_d0_next = cmd_data0;
        resp_d1_next = 8'h0; // R13
        resp_d1_next[STATE_LEVEL_BIT] = sample_reg[pin_sel];
        resp_d1_next[STATE_FALL_BIT] = fall_reg[pin_sel];
        resp_d1_next[STATE_RISE_BIT] = rise_reg[pin_sel];
        resp_d2_next = level_reg[pin_sel];
        resp_d3_next = config_reg[pin_sel] & CONFIG_MAX; // R16
      end else begin
        resp_type_next = RESP_ERROR; // R1
        resp_length_next = 3'h0;
      end
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      resp_valid_reg <= 1'b0;
      resp_type_reg <= 8'h0;
      resp_length_reg <= 3'h0;
      resp_d0_reg <= 8'h0;
      resp_d1_reg <= 8'h0;
      resp_d2_reg <= 8'h0;
      resp_d3_reg <= 8'h0;
    end else begin
      resp_valid_reg <= resp_valid_next;
      resp_type_reg <= resp_type_next;
      resp_length_reg <= resp_length_next;
      resp_d0_reg <= resp_d0_next;
      resp_d1_reg <= resp_d1_next;
      resp_d2_reg <= resp_d2_next;
      resp_d3_reg <= resp_d3_next;
    end
  end

  assign resp_valid = resp_valid_reg;
  assign resp_type = resp_type_reg;
  assign resp_length = resp_length_reg;
  assign resp_data0 = resp_d0_reg;
  assign resp_data1 = resp_d1_reg;
  assign resp_data2 = resp_d2_reg;
  assign resp_data3 = resp_d3_reg;

  property p_bad_index_error;
    @(posedge sys_clk) disable iff (rst)
      (cmd_valid && (cmd_type == CMD_SET_PIN) && (cmd_data0 >= 8'(PINS)))
        |=> (resp_valid && (resp_type == RESP_ERROR));
  endproperty
  a_bad_index_error: assert property (p_bad_index_error) else $error("bad index not refused"); // R1

  property p_reserved_drive;
    @(posedge sys_clk) disable iff (rst)
      (set_cmd && (cmd_length == 2'(SET_LEN_CONFIG)) && (cmd_data2[2:0] == DRIVE_RESERVED))
        |=> (resp_type == RESP_ERROR);
  endproperty
  a_reserved_drive: assert property (p_reserved_drive) else $error("drive 110 accepted"); // R7

  property p_bad_level;
    @(posedge sys_clk) disable iff (rst)
      (set_cmd && (cmd_data1 > LEVEL_HIGH)) |=> (resp_type == RESP_ERROR);
  endproperty
  a_bad_level: assert property (p_bad_level) else $error("invalid level accepted"); // R3

  property p_set_ack;
    @(posedge sys_clk) disable iff (rst)
      set_ok |=> (resp_valid && (resp_type == 8'h62) && (resp_length == 3'h0));
  endproperty
  a_set_ack: assert property (p_set_ack) else $error("set not acknowledged"); // R18

  property p_read_ack;
    @(posedge sys_clk) disable iff (rst)
      (read_cmd && index_ok) |=> (resp_type == 8'h63 && resp_length == 3'h4
        && resp_data1[7:3] == 5'h0 && resp_data3[7:4] == 4'h0);
  endproperty
  a_read_ack: assert property (p_read_ack) else $error("read answer malformed"); // R10

  property p_read_clears;
    @(posedge sys_clk) disable iff (rst)
      (read_cmd && index_ok && !sample_tick) |=> (rise_reg[$past(pin_sel)] == 1'b0);
  endproperty
  a_read_clears: assert property (p_read_clears) else $error("edge flag not cleared"); // R19

  property p_sample_hold;
    @(posedge sys_clk) disable iff (rst)
      !sample_tick |=> $stable(sample_reg);
  endproperty
  a_sample_hold: assert property (p_sample_hold) else $error("sample moved off tick"); // R15

  property p_high_level;
    @(posedge sys_clk) disable iff (rst)
      (level_reg[0] == LEVEL_HIGH) [*3] |-> pwm_level[0];
  endproperty
  a_high_level: assert property (p_high_level) else $error("level 100 not high"); // R3

  property p_save_capture;
    @(posedge sys_clk) disable iff (rst)
      save_defaults |=> (saved_level_reg[0] == $past(level_reg[0])
        && saved_config_reg[0] == $past(config_reg[0]));
  endproperty
  a_save_capture: assert property (p_save_capture) else $error("defaults not captured"); // R17
endmodule // gpio_pwm_port_control

// ==== bench/gpio_host_model.sv ====
// host side of the command link: drives one parsed command per call, collects the answer
// assumes commands are taken on the rising edge and answered in the following cycle
`timescale 1ns/100ps
module gpio_host_model (
  input wire logic sys_clk,
  output logic cmd_valid,
  output logic [7:0] cmd_type,
  output logic [1:0] cmd_length,
  output logic [7:0] cmd_data0,
  output logic [7:0] cmd_data1,
  output logic [7:0] cmd_data2,
  input wire logic resp_valid,
  input wire logic [7:0] resp_type,
  input wire logic [2:0] resp_length,
  input wire logic [7:0] resp_data0,
  input wire logic [7:0] resp_data1,
  input wire logic [7:0] resp_data2,
  input wire logic [7:0] resp_data3
);
  initial begin
    cmd_valid = 1'b0;
    cmd_type = 8'h00;
    cmd_length = 2'h0;
    cmd_data0 = 8'h00;
    cmd_data1 = 8'h00;
    cmd_data2 = 8'h00;
  end

  // caller stands at a falling edge; valid is left high so calls may run back to back
  task automatic send(input logic [7:0] t, input logic [1:0] n, input logic [7:0] a,
      input logic [7:0] b, input logic [7:0] c, output logic got, output logic [7:0] rt,
      output logic [2:0] rn, output logic [31:0] rd);
    cmd_valid = 1'b1;
    cmd_type = t;
    cmd_length = n;
    cmd_data0 = a;
    cmd_data1 = b;
    cmd_data2 = c;
    @(negedge sys_clk);
    got = resp_valid;
    rt = resp_type;
    rn = resp_length;
    rd = {resp_data3, resp_data2, resp_data1, resp_data0};
  endtask

  // released command lines carry inverted junk, never the last value
  task automatic idle();
    cmd_valid = 1'b0;
    cmd_type = ~cmd_type;
    cmd_length = ~cmd_length;
    cmd_data0 = ~cmd_data0;
    cmd_data1 = ~cmd_data1;
    cmd_data2 = ~cmd_data2;
    @(negedge sys_clk);
  endtask
endmodule // gpio_host_model

// ==== bench/test_gpio_pwm_port_control.sv ====
// self-checking bench for the gpio port: integer model of pins, compared at every answer
// assumes short sample and pwm step periods; host model drives the command side
`timescale 1ns/100ps
module test_gpio_pwm_port_control;
  import gpio_port_pkg::*;
  localparam int unsigned SP = 50;
  localparam int unsigned WP = 4;
  logic sys_clk, rst, cmd_valid, save_defaults, resp_valid, got;
  logic [7:0] cmd_type, cmd_data0, cmd_data1, cmd_data2, rt;
  logic [7:0] resp_type, resp_data0, resp_data1, resp_data2, resp_data3;
  logic [1:0] cmd_length;
  logic [2:0] resp_length, rn;
  logic [31:0] rd;
  logic [4:0] pin_in, pin_out, pin_oe, pin_pull_up, pin_pull_down, pin_slow, pin_user_owned;
  int bad_count, checked, seed, i, m, p;
  int lvl[5], cfg[5], pv[5], rf[5], ff[5];
  int ep[9] = '{5, 255, 1, 1, 1, 1, 1, 1, 1};
  int el[9] = '{50, 50, 101, 254, 50, 50, 50, 50, 30};
  int ec[9] = '{9, 9, 9, 9, 16, 6, 14, 9, 6};
  int en[9] = '{3, 3, 3, 3, 3, 3, 3, 1, 2};

  gpio_pwm_port_control #(.SAMPLE_PERIOD(SP), .PWM_STEP_PERIOD(WP)) i_dut (
    .sys_clk(sys_clk), .rst(rst), .cmd_valid(cmd_valid), .cmd_type(cmd_type),
    .cmd_length(cmd_length), .cmd_data0(cmd_data0), .cmd_data1(cmd_data1),
    .cmd_data2(cmd_data2), .save_defaults(save_defaults), .resp_valid(resp_valid),
    .resp_type(resp_type), .resp_length(resp_length), .resp_data0(resp_data0),
    .resp_data1(resp_data1), .resp_data2(resp_data2), .resp_data3(resp_data3),
    .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe), .pin_pull_up(pin_pull_up),
    .pin_pull_down(pin_pull_down), .pin_slow(pin_slow), .pin_user_owned(pin_user_owned));

  gpio_host_model i_host (
    .sys_clk(sys_clk), .cmd_valid(cmd_valid), .cmd_type(cmd_type), .cmd_length(cmd_length),
    .cmd_data0(cmd_data0), .cmd_data1(cmd_data1), .cmd_data2(cmd_data2),
    .resp_valid(resp_valid), .resp_type(resp_type), .resp_length(resp_length),
    .resp_data0(resp_data0), .resp_data1(resp_data1), .resp_data2(resp_data2),
    .resp_data3(resp_data3));

  initial begin
    sys_clk = 1'b0;
    forever #4 sys_clk = ~sys_clk;
  end

  task automatic end_sim();
    if (bad_count == 0 && checked > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  task automatic cmp_resp(input logic [7:0] et, input logic [2:0] en_l, input logic [31:0] ed,
      input bit data_on);
    checked++;
    if (got !== 1'b1 || rt !== et || rn !== en_l || (data_on && rd !== ed)) begin
      bad_count++;
      $display("MISMATCH %0t answer %h/%0d/%h want %h/%0d/%h", $time, rt, rn, rd, et, en_l, ed);
    end
  endtask

  task automatic cmp_bits(input logic [15:0] g, input logic [15:0] e, input string what);
    checked++;
    if (g !== e) begin
      bad_count++;
      $display("MISMATCH %0t %s got %h want %h", $time, what, g, e);
    end
  endtask

  task automatic set_pin(input int sp, input int l, input int cf, input int n, input bit hold = 0);
    bit ok;
    ok = sp < 5 && l <= 100 && (n == 2 || (n == 3 && cf <= 15 && cf % 8 != 6));
    i_host.send(CMD_SET_PIN, 2'(n), 8'(sp), 8'(l), 8'(cf), got, rt, rn, rd);
    if (!hold) i_host.idle();
    if (ok) begin
      lvl[sp] = l;
      if (n == 3) cfg[sp] = cf;
    end
    cmp_resp(ok ? (CMD_SET_PIN | RESP_ACK_BIT) : RESP_ERROR, 3'h0, 32'h0, 0);
  endtask

  task automatic rd_pin(input int sp);
    logic [31:0] e;
    i_host.send(CMD_READ_PIN, 2'd1, 8'(sp), 8'($random(seed)), 8'($random(seed)), got, rt, rn,
      rd);
    i_host.idle();
    if (sp < 5) begin
      e = {8'(cfg[sp]), 8'(lvl[sp]), 5'h0, 1'(rf[sp]), 1'(ff[sp]), 1'(pv[sp]), 8'(sp)};
      cmp_resp(CMD_READ_PIN | RESP_ACK_BIT, 3'h4, e, 1);
      rf[sp] = 0;
      ff[sp] = 0;
    end else begin
      cmp_resp(RESP_ERROR, 3'h0, 32'h0, 0);
    end
  endtask

  // levels are held well past two sample periods, so each change is seen exactly once
  task automatic drive_pins(input logic [4:0] v);
    for (int k = 0; k < 5; k++) begin
      if (v[k] && pv[k] == 0) rf[k] = 1;
      if (!v[k] && pv[k] == 1) ff[k] = 1;
      pv[k] = v[k];
    end
    pin_in = v;
    repeat (3 * SP) @(negedge sys_clk);
  endtask

  // any 100*WP consecutive cycles cover each pwm step exactly WP times
  task automatic pwm_check(input int sp);
    logic [15:0] cnt;
    cnt = 16'h0;
    repeat (100 * WP) begin
      @(negedge sys_clk);
      cnt = cnt + 16'(pin_out[sp]);
    end
    cmp_bits(cnt, 16'(lvl[sp] * WP), "pwm high cycles");
  endtask

  task automatic drive_check();
    int mm;
    bit hh;
    mm = cfg[2] % 8;
    hh = lvl[2] == 100;
    cmp_bits({10'h0, pin_out[2], pin_oe[2], pin_pull_up[2], pin_pull_down[2], pin_slow[2],
      pin_user_owned[2]}, {10'h0, hh, 1'(((hh ? 8'h33 : 8'haa) >> mm) & 8'h01),
      1'(hh && mm == 3), 1'(!hh && mm == 0), 1'(mm == 4 || mm == 5 || mm == 7),
      1'(cfg[2] >= 8)}, "driver");
  endtask

  initial begin
    seed = 48782;
    rst = 1'b1;
    save_defaults = 1'b0;
    pin_in = 5'h00;
    repeat (8) @(posedge sys_clk);
    @(negedge sys_clk);
    rst = 1'b0;
    for (i = 0; i < 5; i++) rd_pin(i);
    for (i = 0; i < 9; i++) set_pin(ep[i], el[i], ec[i], en[i]);
    rd_pin(1);
    rd_pin(5);
    i_host.send(8'h24, 2'd1, 8'h01, 8'h00, 8'h00, got, rt, rn, rd);
    i_host.idle();
    cmp_bits({15'h0, got}, 16'h0, "answer to foreign type");
    for (m = 0; m < 8; m++) begin
      for (i = 0; i < 2; i++) begin
        set_pin(2, i * 100, 8 * i + m, 3);
        repeat (3) @(negedge sys_clk);
        drive_check();
      end
    end
    for (i = 0; i < 20; i++) begin
      p = $unsigned($random(seed)) % 5;
      set_pin(p, $unsigned($random(seed)) % 101, $unsigned($random(seed)) % 16, 2 + i % 2);
      repeat (100 * WP) @(negedge sys_clk);
      pwm_check(p);
      drive_pins(5'($random(seed)));
      if (i % 3 != 0) rd_pin(p);
    end
    set_pin(3, 100, 9, 3, 1);
    rd_pin(3);
    @(negedge sys_clk);
    save_defaults = 1'b1;
    @(negedge sys_clk);
    save_defaults = 1'b0;
    rd_pin(3);
    set_pin(0, 100, 0, 2);
    pwm_check(0);
    // mid-run reset: every pin back to its default, no flags, sample still low
    rst = 1'b1;
    repeat (2) @(negedge sys_clk);
    rst = 1'b0;
    for (i = 0; i < 5; i++) begin
      lvl[i] = int'(DEFAULT_LEVEL);
      cfg[i] = int'(DEFAULT_CONFIG);
      pv[i] = 0;
      rf[i] = 0;
      ff[i] = 0;
    end
    rd_pin(3);
    end_sim();
  end

  initial begin
    repeat (60000) @(posedge sys_clk);
    bad_count++;
    end_sim();
  end
endmodule // test_gpio_pwm_port_control
